// *** hdl/rbd_top.sv ***
// Read-parameter register, dummy-count decode and burst-wrap addressing.
// Assumes host clock and chip enable on pins; mode and address steps are local.
//
// Function
// [RL1] Burst-size code 00/01/10/11 selects 8, 16, 32 or 64 bytes.
// [RL2] Wrap bit 0 reads through the whole array, wrap bit 1 wraps at the burst size.
// [RL3] A dummy field of 1 to 15 gives that many dummy clocks, 0 gives each default.
// [RL4] Default fast read (0Bh/0Dh) uses 8 dummy clocks single-line and 6 in quad mode.
// [RL5] Default dual-output and quad-output reads use 8 dummy clocks, no double-rate form.
// [RL6] Default dual address-and-data read (BBh/BDh) uses 4 dummy clocks.
// [RL7] Default quad address-and-data read (EBh/EDh) uses 6 dummy clocks in both modes.
// [RL8] Identifier and information-row reads use the fast-read dummy count.
// [RL9] The host sets enough dummy clocks to carry its continuous-mode bits.
// [RL10] The host keeps unused continuous-mode bit time high-impedance to avoid contention.
// [RL11] Dual address-and-data double-rate read is refused in quad mode.
// [RL12] The host keeps its serial clock within the limit for command and dummy setting.
// [RL13] 65h writes the persistent copy, C0h or 63h the volatile copy.
// [RL14] At power-up the volatile settings load from the persistent copy.
// [RL15] In wrap mode the address wraps inside its aligned burst-size block.
`timescale 1ns/10ps
`default_nettype none

module rbd_top
  import rbd_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter logic [7:0] UID_OP = 8'h4B,
  parameter logic [7:0] INFORMATION_ROW_READ_OP = 8'h68
)
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic [3:0] io_in,
  input wire logic quad_cmd_mode_in,
  input wire logic addr_load_in,
  input wire logic [ADDR_W-1:0] addr_start_in,
  input wire logic addr_next_in,
  output logic [7:0] read_params_out,
  output logic [7:0] nv_params_out,
  output logic [6:0] burst_len_out,
  output logic burst_wrap_select_out,
  output logic [7:0] cmd_opcode_out,
  output logic [3:0] dummy_cycles_out,
  output logic cmd_valid_out,
  output logic cmd_reject_out,
  output logic loaded_out,
  output logic [ADDR_W-1:0] addr_out
);

  rbd_if lk ();
  rbd_state_e state_r;
  logic [7:0] nv_r;
  logic [7:0] vol_r;
  logic [2:0] sq_r;
  logic [2:0] ss_r;
  logic ev;
  rbd_word_t word;
  logic [7:0] op;
  logic [7:0] par;
  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] inc;

  rbd_link u_link (
    .sck_in(sck_in),
    .cs_n_in(cs_n_in),
    .arst_n_in(arst_n_in),
    .io_in(io_in),
    .lk(lk.link)
  );

  function automatic logic is_read(input logic [7:0] o);
    is_read = (o == `RBD_OP_FAST) || (o == `RBD_OP_FAST_DTR) || (o == UID_OP) ||
      (o == INFORMATION_ROW_READ_OP) || (o == `RBD_OP_DUAL_OUT) || (o == `RBD_OP_QUAD_OUT) ||
      (o == `RBD_OP_DUAL_IO) || (o == `RBD_OP_DUAL_IO_DTR) ||
      (o == `RBD_OP_QUAD_IO) || (o == `RBD_OP_QUAD_IO_DTR);
  endfunction : is_read

  function automatic logic [3:0] dummy_of(input logic [7:0] o, input logic q,
    input logic [3:0] fld);
    dummy_of = 4'h0;
    if (fld != 4'h0)
      dummy_of = fld; // RL3
    else if ((o == `RBD_OP_FAST) || (o == `RBD_OP_FAST_DTR) || (o == UID_OP) ||
      (o == INFORMATION_ROW_READ_OP))
      dummy_of = q ? `RBD_DUMMY_FAST_QUAD : `RBD_DUMMY_FAST_SPI; // RL4 RL8
    else if ((o == `RBD_OP_DUAL_OUT) || (o == `RBD_OP_QUAD_OUT))
      dummy_of = `RBD_DUMMY_OUT; // RL5
    else if ((o == `RBD_OP_DUAL_IO) || (o == `RBD_OP_DUAL_IO_DTR))
      dummy_of = `RBD_DUMMY_DUAL_IO; // RL6
    else if ((o == `RBD_OP_QUAD_IO) || (o == `RBD_OP_QUAD_IO_DTR))
      dummy_of = `RBD_DUMMY_QUAD_IO; // RL7
  endfunction : dummy_of

  // Event crossing from the link clock
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sq_r <= 3'h0;
      ss_r <= 3'h0;
    end
    else
    begin
      sq_r <= {sq_r[1:0], lk.tog_q};
      ss_r <= {ss_r[1:0], lk.tog_s};
    end
  end

  always_comb
  begin
    ev = quad_cmd_mode_in ? (sq_r[2] ^ sq_r[1]) : (ss_r[2] ^ ss_r[1]);
    word = quad_cmd_mode_in ? lk.word_q : lk.word_s;
    op = word[15:8];
    par = word[7:0];
    mask = ADDR_W'(burst_len_out) - {{(ADDR_W-1){1'b0}}, 1'b1};
    inc = addr_out + {{(ADDR_W-1){1'b0}}, 1'b1};
  end

  // Power-up load sequence
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_r <= RBD_ST_LOAD;
    else
    begin
      case (state_r)
        RBD_ST_LOAD: state_r <= RBD_ST_RUN;
        RBD_ST_RUN: state_r <= RBD_ST_RUN;
        default: state_r <= RBD_ST_LOAD;
      endcase
    end
  end

  // Persistent copy
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      nv_r <= `RBD_NV_RESET;
    else if (ev && (op == `RBD_OP_SET_NV))
      nv_r <= par; // RL13
  end

  // Volatile copy
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      vol_r <= `RBD_VOL_RESET;
    else if (state_r == RBD_ST_LOAD)
      vol_r <= nv_r; // RL14
    else if (ev && ((op == `RBD_OP_SET_VOL_A) || (op == `RBD_OP_SET_VOL_B)))
      vol_r <= par; // RL13
  end

  // Decoded settings
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      read_params_out <= `RBD_VOL_RESET;
      nv_params_out <= `RBD_NV_RESET;
      burst_len_out <= `RBD_BURST_BASE;
      burst_wrap_select_out <= 1'b0;
      loaded_out <= 1'b0;
    end
    else
    begin
      read_params_out <= vol_r;
      nv_params_out <= nv_r;
      burst_len_out <= `RBD_BURST_BASE << vol_r[`RBD_BURST_MSB:`RBD_BURST_LSB]; // RL1
      burst_wrap_select_out <= vol_r[`RBD_WRAP_BIT];
      loaded_out <= (state_r == RBD_ST_RUN);
    end
  end

  // Read command decode
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cmd_opcode_out <= 8'h00;
      dummy_cycles_out <= 4'h0;
      cmd_valid_out <= 1'b0;
      cmd_reject_out <= 1'b0;
    end
    else
    begin
      cmd_valid_out <= 1'b0;
      if (ev && is_read(op))
      begin
        cmd_opcode_out <= op;
        if (quad_cmd_mode_in && (op == `RBD_OP_DUAL_IO_DTR))
        begin
          cmd_reject_out <= 1'b1; // RL11
          dummy_cycles_out <= 4'h0;
        end
        else
        begin
          cmd_reject_out <= 1'b0;
          cmd_valid_out <= 1'b1;
          dummy_cycles_out <= dummy_of(op, quad_cmd_mode_in,
            vol_r[`RBD_DUMMY_MSB:`RBD_DUMMY_LSB]); // RL3
        end
      end
    end
  end

  // Continuous read address
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      addr_out <= '0;
    else if (addr_load_in)
      addr_out <= addr_start_in;
    else if (addr_next_in)
    begin
      if (burst_wrap_select_out)
        addr_out <= (addr_out & ~mask) | (inc & mask); // RL2 RL15
      else
        addr_out <= inc; // RL2
    end
  end

  property p_burst_len;
    @(posedge mclk_in) disable iff (!arst_n_in)
    $stable(vol_r) |=> (burst_len_out == (`RBD_BURST_BASE << $past(vol_r[1:0])));
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst length decode wrong"); // RL1

  property p_linear;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (addr_next_in && !addr_load_in && !burst_wrap_select_out) |=>
      (addr_out == $past(addr_out) + 1'b1);
  endproperty
  a_linear: assert property (p_linear) else $error("linear address step wrong"); // RL2

  property p_wrap_block;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (addr_next_in && !addr_load_in && burst_wrap_select_out && $stable(burst_len_out)) |=>
      (((addr_out ^ $past(addr_out)) & ~$past(mask)) == '0) &&
      ((addr_out & $past(mask)) == (($past(addr_out) + 1'b1) & $past(mask)));
  endproperty
  a_wrap_block: assert property (p_wrap_block) else $error("wrap left burst block"); // RL15

  property p_field;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ev && is_read(op) && (vol_r[6:3] != 4'h0) && !(quad_cmd_mode_in && op == 8'hBD)) |=>
      (dummy_cycles_out == $past(vol_r[6:3])) && cmd_valid_out;
  endproperty
  a_field: assert property (p_field) else $error("selected dummy count not applied"); // RL3

  property p_fast;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ev && (vol_r[6:3] == 4'h0) && ((op == 8'h0B) || (op == 8'h0D) || (op == UID_OP) ||
      (op == INFORMATION_ROW_READ_OP))) |=>
      (dummy_cycles_out == ($past(quad_cmd_mode_in) ? 4'h6 : 4'h8));
  endproperty
  a_fast: assert property (p_fast) else $error("fast read default dummy wrong"); // RL4 RL8

  property p_out;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ev && (vol_r[6:3] == 4'h0) && ((op == 8'h3B) || (op == 8'h6B))) |=>
      (dummy_cycles_out == 4'h8);
  endproperty
  a_out: assert property (p_out) else $error("output read default dummy wrong"); // RL5

  property p_dual_io;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ev && (vol_r[6:3] == 4'h0) && (op == 8'hBB)) |=> (dummy_cycles_out == 4'h4);
  endproperty
  a_dual_io: assert property (p_dual_io) else $error("dual io default dummy wrong"); // RL6

  property p_quad_io;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ev && (vol_r[6:3] == 4'h0) && ((op == 8'hEB) || (op == 8'hED))) |=>
      (dummy_cycles_out == 4'h6);
  endproperty
  a_quad_io: assert property (p_quad_io) else $error("quad io default dummy wrong"); // RL7

  property p_reject;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ev && quad_cmd_mode_in && (op == 8'hBD)) |=> (cmd_reject_out && !cmd_valid_out);
  endproperty
  a_reject: assert property (p_reject) else $error("quad double-rate dual io accepted"); // RL11

  property p_nv_write;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ev && (op == 8'h65)) |=> ##1 (nv_params_out == $past(par, 2));
  endproperty
  a_nv_write: assert property (p_nv_write) else $error("persistent write lost"); // RL13

  property p_powerup;
    @(posedge mclk_in) disable iff (!arst_n_in)
    (state_r == RBD_ST_LOAD) |=> (vol_r == $past(nv_r)) ##1 loaded_out;
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up load missing"); // RL14

endmodule : rbd_top

`default_nettype wire

// *** inc/rbd_defines.svh ***
// Constants of the read-parameter block: opcodes, field positions, reset values.
// Assumes inclusion by the package and the design modules.
`ifndef RBD_DEFINES_SVH
`define RBD_DEFINES_SVH

// Register commands
`define RBD_OP_SET_NV 8'h65
`define RBD_OP_SET_VOL_A 8'hC0
`define RBD_OP_SET_VOL_B 8'h63

// Read commands
`define RBD_OP_FAST 8'h0B
`define RBD_OP_FAST_DTR 8'h0D
`define RBD_OP_DUAL_OUT 8'h3B
`define RBD_OP_QUAD_OUT 8'h6B
`define RBD_OP_DUAL_IO 8'hBB
`define RBD_OP_DUAL_IO_DTR 8'hBD
`define RBD_OP_QUAD_IO 8'hEB
`define RBD_OP_QUAD_IO_DTR 8'hED

// Default dummy counts
`define RBD_DUMMY_FAST_SPI 4'h8
`define RBD_DUMMY_FAST_QUAD 4'h6
`define RBD_DUMMY_OUT 4'h8
`define RBD_DUMMY_DUAL_IO 4'h4
`define RBD_DUMMY_QUAD_IO 4'h6

// Field positions of the read-parameter register
`define RBD_BURST_LSB 0
`define RBD_BURST_MSB 1
`define RBD_WRAP_BIT 2
`define RBD_DUMMY_LSB 3
`define RBD_DUMMY_MSB 6

// Reset values
`define RBD_NV_RESET 8'h00
`define RBD_VOL_RESET 8'h00
`define RBD_BURST_BASE 7'h08

// Link edge counts at which a command word is complete
`define RBD_EDGES_QUAD 5'h04
`define RBD_EDGES_SINGLE 5'h10

`endif

// *** inc/rbd_pkg.sv ***
// Types of the read-parameter block.
// Assumes rbd_defines.svh on the include path.
`include "rbd_defines.svh"

package rbd_pkg;

  typedef enum logic [1:0] {
    RBD_ST_LOAD = 2'b01,
    RBD_ST_RUN = 2'b10
  } rbd_state_e;

  typedef logic [15:0] rbd_word_t;

endpackage : rbd_pkg

// *** inc/rbd_if.sv ***
// Carrier between the link-clock front end and the core.
// Assumes the link side owns every signal; the core only reads.
`timescale 1ns/10ps
`default_nettype none

interface rbd_if;
  import rbd_pkg::*;
  logic tog_q;
  logic tog_s;
  rbd_word_t word_q;
  rbd_word_t word_s;

  modport link (output tog_q, output tog_s, output word_q, output word_s);
  modport core (input tog_q, input tog_s, input word_q, input word_s);
endinterface : rbd_if

`default_nettype wire

// *** hdl/rbd_link.sv ***
// Serial front end on the host's clock: gathers opcode and first data byte.
// Assumes the host's clock runs only inside frames framed by chip enable.
`timescale 1ns/10ps
`default_nettype none

module rbd_link
  import rbd_pkg::*;
(
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic arst_n_in,
  input wire logic [3:0] io_in,
  rbd_if.link lk
);

  logic [4:0] edges_r;
  rbd_word_t shift_s_r;
  rbd_word_t shift_q_r;

  // Edge count and shifters, cleared between frames
  always_ff @(posedge sck_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      edges_r <= 5'h00;
      shift_s_r <= 16'h0000;
      shift_q_r <= 16'h0000;
    end
    else
    begin
      if (edges_r != 5'h1F)
        edges_r <= edges_r + 5'h01;
      shift_s_r <= {shift_s_r[14:0], io_in[0]};
      shift_q_r <= {shift_q_r[11:0], io_in};
    end
  end

  // Completed words held until the same point of the next frame
  always_ff @(posedge sck_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lk.tog_q <= 1'b0;
      lk.tog_s <= 1'b0;
      lk.word_q <= 16'h0000;
      lk.word_s <= 16'h0000;
    end
    else if (!cs_n_in)
    begin
      if (edges_r == `RBD_EDGES_QUAD - 5'h01)
      begin
        lk.word_q <= {shift_q_r[11:0], io_in};
        lk.tog_q <= ~lk.tog_q;
      end
      if (edges_r == `RBD_EDGES_SINGLE - 5'h01)
      begin
        lk.word_s <= {shift_s_r[14:0], io_in[0]};
        lk.tog_s <= ~lk.tog_s;
      end
    end
  end

endmodule : rbd_link

`default_nettype wire

// *** sim/rbd_host.sv ***
// Host controller model: frames one 16-bit word onto sck, cs_n and io.
// Assumes the bench calls frame() with frames kept apart.
`timescale 1ns/10ps
`default_nettype none

module rbd_host;
  logic sck = 1'b0;
  logic cs_n = 1'b1;
  logic [3:0] io = 4'h5;

  // Sends no continuous-mode bits, so no dummy time is shared
  task automatic frame(input logic quad, input logic [15:0] w);
    int n;
    n = quad ? 4 : 16;
    #7;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      if (quad)
        io = w[15-4*i -: 4];
      else
        io = {~io[3:1], w[15-i]};
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end
    cs_n = 1'b1;
    io = ~io;
  endtask : frame
endmodule : rbd_host

`default_nettype wire

// *** sim/test_read_burst_dummy_config.sv ***
// Bench of the read-parameter block: register writes, read decode, addressing.
// Assumes rbd_host drives the serial pins; mclk-side inputs driven here.
`timescale 1ns/10ps
`default_nettype none

module test_read_burst_dummy_config;
  import rbd_pkg::*;
  localparam logic [7:0] UID = 8'h4B;
  localparam logic [7:0] IRR = 8'h68;
  typedef struct packed {logic q; logic [7:0] op; logic [3:0] fld; logic [3:0] dum; logic rej;} rbd_row_s;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic quad_in = 1'b0;
  logic addr_load_in = 1'b0;
  logic addr_next_in = 1'b0;
  logic [23:0] addr_start_in = 24'h000000;
  logic [7:0] read_params_out, nv_params_out, cmd_opcode_out;
  logic [6:0] burst_len_out;
  logic [3:0] dummy_cycles_out;
  logic burst_wrap_select_out, cmd_valid_out, cmd_reject_out, loaded_out;
  logic [23:0] addr_out;
  int errors = 0;
  int samples_checked = 0;
  rbd_row_s rows [19] = '{
    '{1'b0, 8'h0B, 4'h0, 4'h8, 1'b0}, '{1'b0, 8'h0D, 4'h0, 4'h8, 1'b0},
    '{1'b0, 8'h3B, 4'h0, 4'h8, 1'b0}, '{1'b0, 8'h6B, 4'h0, 4'h8, 1'b0},
    '{1'b0, 8'hBB, 4'h0, 4'h4, 1'b0}, '{1'b0, 8'hBD, 4'h0, 4'h4, 1'b0},
    '{1'b0, 8'hEB, 4'h0, 4'h6, 1'b0}, '{1'b0, 8'hED, 4'h0, 4'h6, 1'b0},
    '{1'b0, UID, 4'h0, 4'h8, 1'b0}, '{1'b0, IRR, 4'h0, 4'h8, 1'b0},
    '{1'b1, 8'h0B, 4'h0, 4'h6, 1'b0}, '{1'b1, 8'h0D, 4'h0, 4'h6, 1'b0},
    '{1'b1, 8'hEB, 4'h0, 4'h6, 1'b0}, '{1'b1, 8'hED, 4'h0, 4'h6, 1'b0},
    '{1'b1, UID, 4'h0, 4'h6, 1'b0}, '{1'b0, 8'h0B, 4'hF, 4'hF, 1'b0},
    '{1'b0, 8'hBB, 4'h9, 4'h9, 1'b0}, '{1'b0, 8'hEB, 4'h1, 4'h1, 1'b0},
    '{1'b1, 8'hBD, 4'h0, 4'h0, 1'b1}};

  rbd_host host();

  rbd_top #(.ADDR_W(24), .UID_OP(UID), .INFORMATION_ROW_READ_OP(IRR)) uut (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .sck_in(host.sck), .cs_n_in(host.cs_n),
    .io_in(host.io), .quad_cmd_mode_in(quad_in), .addr_load_in(addr_load_in),
    .addr_start_in(addr_start_in), .addr_next_in(addr_next_in),
    .read_params_out(read_params_out), .nv_params_out(nv_params_out),
    .burst_len_out(burst_len_out), .burst_wrap_select_out(burst_wrap_select_out),
    .cmd_opcode_out(cmd_opcode_out), .dummy_cycles_out(dummy_cycles_out),
    .cmd_valid_out(cmd_valid_out), .cmd_reject_out(cmd_reject_out),
    .loaded_out(loaded_out), .addr_out(addr_out));

  initial
  begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  task automatic tick();
    @(posedge mclk_in);
    #2;
  endtask : tick

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // Register write in single-line mode, then settle
  task automatic setp(input logic [7:0] cmd, input logic [7:0] v);
    quad_in = 1'b0;
    host.frame(1'b0, {cmd, v});
    repeat (8) tick();
  endtask : setp

  task automatic rd(input logic q, input logic [7:0] op);
    int k;
    quad_in = q;
    host.frame(q, {op, 8'h00});
    for (k = 0; k < 40 && cmd_valid_out !== 1'b1 && cmd_reject_out !== 1'b1; k++)
      tick();
    if (k == 40)
    begin
      errors++;
      complete_run();
    end
  endtask : rd

  task automatic step(input logic ld, input logic [23:0] a, input logic [23:0] e);
    addr_load_in = ld;
    addr_next_in = !ld;
    addr_start_in = a;
    tick();
    check(addr_out, e);
  endtask : step

  initial
  begin
    repeat (16) tick();
    check(read_params_out, 24'h0);
    check(burst_len_out, 24'h8);
    arst_n_in = 1'b1;
    repeat (3) tick();
    check(loaded_out, 24'h1);
    check(read_params_out, 24'h0);
    foreach (rows[i])
    begin
      setp(8'hC0, {1'b0, rows[i].fld, 3'h0});
      rd(rows[i].q, rows[i].op);
      check(cmd_opcode_out, rows[i].op);
      check(dummy_cycles_out, rows[i].dum);
      check(cmd_reject_out, rows[i].rej);
      check(cmd_valid_out, !rows[i].rej);
    end
    quad_in = 1'b0;
    for (int b = 0; b < 4; b++)
    begin
      setp(8'h63, {5'h00, 1'b1, b[1:0]});
      check(read_params_out, {5'h00, 1'b1, b[1:0]});
      check(burst_len_out, 7'h08 << b);
      check(burst_wrap_select_out, 24'h1);
    end
    step(1'b1, 24'h00007F, 24'h00007F);
    step(1'b0, 24'h0, 24'h000040);
    setp(8'hC0, 8'h04);
    step(1'b1, 24'h12343E, 24'h12343E);
    step(1'b0, 24'h0, 24'h12343F);
    step(1'b0, 24'h0, 24'h123438);
    step(1'b0, 24'h0, 24'h123439);
    setp(8'hC0, 8'h07);
    check(burst_wrap_select_out, 24'h1);
    setp(8'hC0, 8'h03);
    check(burst_wrap_select_out, 24'h0);
    step(1'b1, 24'h00003E, 24'h00003E);
    step(1'b0, 24'h0, 24'h00003F);
    step(1'b0, 24'h0, 24'h000040);
    addr_next_in = 1'b0;
    setp(8'h65, 8'h2D);
    check(nv_params_out, 24'h2D);
    check(read_params_out, 24'h03);
    arst_n_in = 1'b0;
    tick();
    check(read_params_out, 24'h0);
    check(nv_params_out, 24'h0);
    check(burst_len_out, 24'h8);
    check(loaded_out, 24'h0);
    check(cmd_valid_out, 24'h0);
    arst_n_in = 1'b1;
    tick();
    check(loaded_out, 24'h0);
    tick();
    check(loaded_out, 24'h1);
    check(read_params_out, 24'h0);
    complete_run();
  end
endmodule : test_read_burst_dummy_config

`default_nettype wire
